// *** verilog/fes_pkg.sv ***
// constants, types and helpers shared by the erase and sleep control block
package fes_pkg;

   // =========================================================================
   // command codes
   localparam logic [7:0] CMD_SMALL_CLEAR = 8'h20;
   localparam logic [7:0] CMD_HALF_CLEAR  = 8'h52;
   localparam logic [7:0] CMD_BLOCK_CLEAR = 8'hd8;
   localparam logic [7:0] CMD_FULL_A      = 8'hc7;
   localparam logic [7:0] CMD_FULL_B      = 8'h60;
   localparam logic [7:0] CMD_SLEEP_ENTRY = 8'hb9;
   localparam logic [7:0] CMD_WAKE_ID     = 8'hab;
   localparam logic [7:0] CMD_WRITE_UNLK  = 8'h06;
   localparam logic [7:0] CMD_QUAD_ENTER  = 8'h38;

   // =========================================================================
   // frame shape
   localparam logic [2:0] BYTES_CMD_ONLY  = 3'h1;
   localparam logic [2:0] BYTES_CMD_ADDR  = 3'h4;
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
   localparam logic [3:0] BITS_QUAD_EDGE  = 4'h4;

   // =========================================================================
   // timing: times in their own unit, counts derived at the clock rate
   localparam int CLK_MHZ               = 100;
   localparam int SMALL_CLEAR_TIME_US   = 1000;
   localparam int HALF_CLEAR_TIME_US    = 2000;
   localparam int BLOCK_CLEAR_TIME_US   = 3000;
   localparam int FULL_CLEAR_TIME_US    = 8000;
   localparam int SLEEP_ENTRY_DELAY_NS  = 3000;
   localparam int WAKE_DELAY_NS         = 3000;
   localparam int WAKE_ID_DELAY_NS      = 1800;
   localparam int SMALL_CLEAR_CYC = SMALL_CLEAR_TIME_US * CLK_MHZ;
   localparam int HALF_CLEAR_CYC  = HALF_CLEAR_TIME_US * CLK_MHZ;
   localparam int BLOCK_CLEAR_CYC = BLOCK_CLEAR_TIME_US * CLK_MHZ;
   localparam int FULL_CLEAR_CYC  = FULL_CLEAR_TIME_US * CLK_MHZ;
   localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int WAKE_CYC        = (WAKE_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int WAKE_ID_CYC     = (WAKE_ID_DELAY_NS * CLK_MHZ + 999) / 1000;

   // =========================================================================
   // memory geometry and reset values
   localparam logic [6:0] NUM_BLK64       = 7'h40;
   localparam logic [3:0] PROT_ALL_LEVEL  = 4'h7;
   localparam logic       RST_LATCH       = 1'b0;
   localparam logic       RST_QUAD        = 1'b0;
   localparam logic       RST_BUSY        = 1'b0;

   // =========================================================================
   // types
   typedef enum logic [1:0] {
      CLR_SMALL = 2'h0, CLR_HALF = 2'h1, CLR_BLOCK = 2'h2, CLR_FULL = 2'h3
   } fes_clear_t;
   typedef enum logic [1:0] {
      ST_WAIT_CMD = 2'h0, ST_TAKE_ADDR = 2'h1, ST_SEND_ID = 2'h3,
      ST_DROP = 2'h2
   } fes_frame_t;
   typedef enum logic [1:0] {
      PW_AWAKE = 2'h0, PW_ENTER = 2'h1, PW_SLEEP = 2'h3, PW_WAKE = 2'h2
   } fes_power_t;

   // =========================================================================
   // helpers
   function automatic logic [31:0] fes_load(input int unsigned cyc);
      fes_load = (cyc > 1) ? 32'(cyc - 1) : 32'h0;
   endfunction : fes_load

   // top 64k blocks guarded, count doubling per level, level 7 up guards all
   function automatic logic fes_protected(input logic [3:0]  lvl,
                                          input logic [23:0] addr);
      logic [6:0] span;
      span = NUM_BLK64 >> (PROT_ALL_LEVEL - lvl);
      if (lvl == 4'h0)
         fes_protected = 1'b0;
      else if (lvl >= PROT_ALL_LEVEL)
         fes_protected = 1'b1;
      else
         fes_protected = {1'b0, addr[21:16]} >= (NUM_BLK64 - span);
   endfunction : fes_protected

   function automatic logic [23:0] fes_base(input fes_clear_t  kind,
                                            input logic [23:0] addr);
      case (kind)
         CLR_SMALL: fes_base = {addr[23:12], 12'h000};
         CLR_HALF:  fes_base = {addr[23:15], 15'h0000};
         CLR_BLOCK: fes_base = {addr[23:16], 16'h0000};
         default:   fes_base = 24'h000000;
      endcase
   endfunction : fes_base

endpackage : fes_pkg

// *** verilog/fes_link_if.sv ***
// carrier between the link shifter and the command sequencer
`timescale 1ns/1ps
interface fes_link_if;
   logic       quad;
   logic       byte_vld;
   logic [7:0] byte_val;
   logic [2:0] byte_num;
   logic       aligned;
   logic       sel_rise;
   logic       id_en;
   logic [7:0] id_val;

   modport shf (input quad, id_en, id_val,
                output byte_vld, byte_val, byte_num, aligned, sel_rise);
   modport ctl (output quad, id_en, id_val,
                input byte_vld, byte_val, byte_num, aligned, sel_rise);
endinterface : fes_link_if

// *** verilog/fes_shifter.sv ***
// link front end: pin synchronisers, byte assembly, id shift-out
`timescale 1ns/1ps
module fes_shifter
   import fes_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       sclk,
   input  wire logic       select_n,
   input  wire logic [3:0] dq_in,
   fes_link_if.shf         ln,
   output logic            so,
   output logic            so_oe
);

   // =========================================================================
   // synchronisers
   logic [2:0] sclk_r, sel_r;
   logic [3:0] dq1_r, dq2_r;
   logic       sclk_rise, sclk_fall, sel_fall;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclk_r <= 3'h0;
         sel_r  <= 3'h7;
         dq1_r  <= 4'h0;
         dq2_r  <= 4'h0;
      end else begin
         sclk_r <= {sclk_r[1:0], sclk};
         sel_r  <= {sel_r[1:0], select_n};
         dq1_r  <= dq_in;
         dq2_r  <= dq1_r;
      end
   end

   // capture on rising serial clock edges only [RULE22]
   assign sclk_rise   = sclk_r[1] & ~sclk_r[2] & ~sel_r[1];
   assign sclk_fall   = ~sclk_r[1] & sclk_r[2] & ~sel_r[1];
   assign sel_fall    = ~sel_r[1] & sel_r[2];
   assign ln.sel_rise = sel_r[1] & ~sel_r[2];

   // =========================================================================
   // byte assembly and id output
   logic [7:0] sh_r, sh_nxt, byte_r, byte_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [2:0] num_r, num_nxt, out_r, out_nxt;
   logic       vld_r, vld_nxt, so_r, so_nxt, oe_r, oe_nxt;

   always_comb begin
      sh_nxt   = sh_r;
      bit_nxt  = bit_r;
      num_nxt  = num_r;
      out_nxt  = out_r;
      byte_nxt = byte_r;
      so_nxt   = so_r;
      vld_nxt  = 1'b0;
      oe_nxt   = ~sel_r[1] & ln.id_en;
      if (sel_fall) begin
         bit_nxt = 4'h0;
         num_nxt = 3'h0;
         out_nxt = 3'h0;
      end else if (sclk_rise) begin
         // four lines per edge in quad mode [RULE21]
         if (ln.quad) begin
            sh_nxt  = {sh_r[3:0], dq2_r};
            bit_nxt = bit_r + BITS_QUAD_EDGE;
         end else begin
            sh_nxt  = {sh_r[6:0], dq2_r[0]};
            bit_nxt = bit_r + 4'h1;
         end
         if (bit_nxt == BITS_PER_BYTE) begin
            bit_nxt  = 4'h0;
            vld_nxt  = 1'b1;
            byte_nxt = sh_nxt;
            if (num_r != 3'h7)
               num_nxt = num_r + 3'h1;
         end
      end else if (sclk_fall && ln.id_en) begin
         // msb first, wraps to repeat the id [RULE18]
         so_nxt  = ln.id_val[3'h7 - out_r];
         out_nxt = out_r + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sh_r   <= 8'h00;
         byte_r <= 8'h00;
         bit_r  <= 4'h0;
         num_r  <= 3'h0;
         out_r  <= 3'h0;
         vld_r  <= 1'b0;
         so_r   <= 1'b0;
         oe_r   <= 1'b0;
      end else begin
         sh_r   <= sh_nxt;
         byte_r <= byte_nxt;
         bit_r  <= bit_nxt;
         num_r  <= num_nxt;
         out_r  <= out_nxt;
         vld_r  <= vld_nxt;
         so_r   <= so_nxt;
         oe_r   <= oe_nxt;
      end
   end

   assign ln.byte_vld = vld_r;
   assign ln.byte_val = byte_r;
   assign ln.byte_num = num_r;
   assign ln.aligned  = (bit_r == 4'h0);
   assign so          = so_r;
   assign so_oe       = oe_r;

endmodule : fes_shifter

// *** verilog/fes_top.sv ***
// erase family and deep sleep command sequencer of the serial flash
//
// Overview of operation
// [RULE1] code 20h plus three address bytes erases the 4k sector holding it
// [RULE2] code 52h plus three address bytes erases the 32k block holding it
// [RULE3] code d8h plus three address bytes erases the 64k block holding it
// [RULE4] code c7h or 60h alone erases the whole array
// [RULE5] erases need the unlock latch; the unlock command sets it
// [RULE6] address erases run only if select rises right after bit 32
// [RULE7] whole erase and sleep run only if select rises after bit eight
// [RULE8] host holds select low across the whole sequence
// [RULE9] select rise starts the timed cycle; busy high until it ends
// [RULE10] unlock latch clears during each erase cycle
// [RULE11] address erase into a protected region is not executed
// [RULE12] whole erase runs only with all protect bits zero
// [RULE13] code b9h enters sleep after the entry delay; nothing else does
// [RULE14] while asleep every command except abh is ignored
// [RULE15] sleep command during a busy cycle is rejected
// [RULE16] deselect gives standby; power-up is always standby
// [RULE17] abh alone wakes after wake delay; host keeps select high
// [RULE18] abh plus three dummy bytes streams the 8-bit id, msb first
// [RULE19] deselect after abh: immediate if awake, else after id wake delay
// [RULE20] abh during a busy cycle is not decoded
// [RULE21] erases also work in quad command mode, entered with 38h
// [RULE22] command and address bits are sampled on rising serial clock
// [RULE23] cycle and delay lengths are configurable cycle counts
`timescale 1ns/1ps
module fes_top
   import fes_pkg::*;
#(
   parameter int unsigned SMALL_CYC    = SMALL_CLEAR_CYC,
   parameter int unsigned HALF_CYC     = HALF_CLEAR_CYC,
   parameter int unsigned BLOCK_CYC    = BLOCK_CLEAR_CYC,
   parameter int unsigned FULL_CYC     = FULL_CLEAR_CYC,
   parameter int unsigned SLEEP_CYC    = SLEEP_ENTRY_CYC,
   parameter int unsigned WAKE_CYC_P   = WAKE_CYC,
   parameter int unsigned WAKE_ID_CYC_P = WAKE_ID_CYC,
   // arbitrary value
   parameter logic [7:0]  DEVICE_ID    = 8'h5a
)
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        sclk,
   input  wire logic        select_n,
   input  wire logic [3:0]  dq_in,
   input  wire logic [3:0]  protect_bits,
   output logic             serial_out,
   output logic             serial_out_oe,
   output logic             busy_flag,
   output logic             write_unlock_latch,
   output logic             quad_command_mode,
   output logic             sleep_mode,
   output logic             clear_start,
   output logic [1:0]       clear_kind,
   output logic [23:0]      clear_base
);

   fes_link_if ln ();

   fes_shifter u_shifter (
      .clk      (clk),
      .resetn   (resetn),
      .sclk     (sclk),
      .select_n (select_n),
      .dq_in    (dq_in),
      .ln       (ln),
      .so       (serial_out),
      .so_oe    (serial_out_oe)
   );

   // =========================================================================
   // protect level synchroniser
   logic [3:0] prot1_r, prot_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prot1_r <= 4'h0;
         prot_r  <= 4'h0;
      end else begin
         prot1_r <= protect_bits;
         prot_r  <= prot1_r;
      end
   end

   // =========================================================================
   // sequencer state
   fes_frame_t  state_r, state_nxt;
   fes_power_t  pwr_r, pwr_nxt;
   fes_clear_t  kind_r, kind_nxt;
   logic [7:0]  cmd_r, cmd_nxt;
   logic [23:0] addr_r, addr_nxt, base_r, base_nxt;
   logic [31:0] clr_cnt_r, clr_cnt_nxt, pwr_cnt_r, pwr_cnt_nxt;
   logic        latch_r, latch_nxt, busy_r, busy_nxt;
   logic        quad_r, quad_nxt, start_r, start_nxt;
   logic        sleep_r, sleep_nxt;
   logic        listen, exact_cmd, exact_addr, addr_cmd, full_cmd;

   assign listen     = (pwr_r == PW_AWAKE) && !busy_r;
   assign exact_cmd  = (ln.byte_num == BYTES_CMD_ONLY) && ln.aligned;
   assign exact_addr = (ln.byte_num == BYTES_CMD_ADDR) && ln.aligned;
   assign addr_cmd   = (cmd_r == CMD_SMALL_CLEAR) ||
                       (cmd_r == CMD_HALF_CLEAR) ||
                       (cmd_r == CMD_BLOCK_CLEAR);
   assign full_cmd   = (cmd_r == CMD_FULL_A) || (cmd_r == CMD_FULL_B);

   always_comb begin
      state_nxt   = state_r;
      pwr_nxt     = pwr_r;
      kind_nxt    = kind_r;
      cmd_nxt     = cmd_r;
      addr_nxt    = addr_r;
      base_nxt    = base_r;
      clr_cnt_nxt = clr_cnt_r;
      pwr_cnt_nxt = pwr_cnt_r;
      latch_nxt   = latch_r;
      busy_nxt    = busy_r;
      quad_nxt    = quad_r;
      start_nxt   = 1'b0;

      // self-timed erase cycle [RULE9]
      if (busy_r) begin
         if (clr_cnt_r == 32'h0)
            busy_nxt = 1'b0;
         else
            clr_cnt_nxt = clr_cnt_r - 32'h1;
      end

      // sleep entry and wake timers [RULE13] [RULE17] [RULE19]
      case (pwr_r)
         PW_ENTER, PW_WAKE: begin
            if (pwr_cnt_r == 32'h0)
               pwr_nxt = (pwr_r == PW_ENTER) ? PW_SLEEP : PW_AWAKE;
            else
               pwr_cnt_nxt = pwr_cnt_r - 32'h1;
         end
         default: ;
      endcase

      if (ln.byte_vld) begin
         case (state_r)
            ST_WAIT_CMD: begin
               cmd_nxt   = ln.byte_val;
               state_nxt = ST_DROP;
               if (pwr_r == PW_SLEEP) begin
                  if (ln.byte_val == CMD_WAKE_ID)  // [RULE14]
                     state_nxt = ST_TAKE_ADDR;
               end else if (listen) begin  // [RULE15] [RULE20]
                  case (ln.byte_val)
                     CMD_WRITE_UNLK: latch_nxt = 1'b1;  // [RULE5]
                     CMD_QUAD_ENTER: quad_nxt = 1'b1;  // [RULE21]
                     CMD_SMALL_CLEAR, CMD_HALF_CLEAR, CMD_BLOCK_CLEAR,
                     CMD_FULL_A, CMD_FULL_B, CMD_SLEEP_ENTRY,
                     CMD_WAKE_ID:
                        state_nxt = ST_TAKE_ADDR;
                     default: ;
                  endcase
               end
            end
            ST_TAKE_ADDR: begin
               addr_nxt = {addr_r[15:0], ln.byte_val};
               if (cmd_r == CMD_WAKE_ID && ln.byte_num == BYTES_CMD_ADDR)
                  state_nxt = ST_SEND_ID;  // [RULE18]
            end
            default: ;
         endcase
      end

      // deselect closes the frame and returns to standby [RULE16]
      if (ln.sel_rise) begin
         state_nxt = ST_WAIT_CMD;
         if (state_r == ST_TAKE_ADDR || state_r == ST_SEND_ID) begin
            if (addr_cmd && exact_addr && latch_r) begin  // [RULE6]
               if (!fes_protected(prot_r, addr_r)) begin  // [RULE11]
                  case (cmd_r)
                     CMD_SMALL_CLEAR: begin  // [RULE1]
                        kind_nxt    = CLR_SMALL;
                        clr_cnt_nxt = fes_load(SMALL_CYC);  // [RULE23]
                     end
                     CMD_HALF_CLEAR: begin  // [RULE2]
                        kind_nxt    = CLR_HALF;
                        clr_cnt_nxt = fes_load(HALF_CYC);
                     end
                     default: begin  // [RULE3]
                        kind_nxt    = CLR_BLOCK;
                        clr_cnt_nxt = fes_load(BLOCK_CYC);
                     end
                  endcase
                  busy_nxt  = 1'b1;
                  latch_nxt = 1'b0;  // [RULE10]
                  start_nxt = 1'b1;
                  base_nxt  = fes_base(kind_nxt, addr_r);
               end
            end else if (full_cmd && exact_cmd && latch_r &&
                         prot_r == 4'h0) begin  // [RULE4] [RULE7] [RULE12]
               kind_nxt    = CLR_FULL;
               clr_cnt_nxt = fes_load(FULL_CYC);
               busy_nxt    = 1'b1;
               latch_nxt   = 1'b0;  // [RULE10]
               start_nxt   = 1'b1;
               base_nxt    = fes_base(CLR_FULL, addr_r);
            end else if (cmd_r == CMD_SLEEP_ENTRY && exact_cmd) begin
               pwr_nxt     = PW_ENTER;  // [RULE7] [RULE13]
               pwr_cnt_nxt = fes_load(SLEEP_CYC);
            end else if (cmd_r == CMD_WAKE_ID && pwr_r == PW_SLEEP) begin
               pwr_nxt     = PW_WAKE;  // [RULE17] [RULE19]
               pwr_cnt_nxt = exact_cmd ? fes_load(WAKE_CYC_P)
                                       : fes_load(WAKE_ID_CYC_P);
            end
         end
      end
      sleep_nxt = (pwr_nxt == PW_SLEEP);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r   <= ST_WAIT_CMD;
         pwr_r     <= PW_AWAKE;  // [RULE16]
         kind_r    <= CLR_SMALL;
         cmd_r     <= 8'h00;
         addr_r    <= 24'h000000;
         base_r    <= 24'h000000;
         clr_cnt_r <= 32'h0;
         pwr_cnt_r <= 32'h0;
         latch_r   <= RST_LATCH;
         busy_r    <= RST_BUSY;
         quad_r    <= RST_QUAD;
         start_r   <= 1'b0;
         sleep_r   <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         pwr_r     <= pwr_nxt;
         kind_r    <= kind_nxt;
         cmd_r     <= cmd_nxt;
         addr_r    <= addr_nxt;
         base_r    <= base_nxt;
         clr_cnt_r <= clr_cnt_nxt;
         pwr_cnt_r <= pwr_cnt_nxt;
         latch_r   <= latch_nxt;
         busy_r    <= busy_nxt;
         quad_r    <= quad_nxt;
         start_r   <= start_nxt;
         sleep_r   <= sleep_nxt;
      end
   end

   assign ln.quad            = quad_r;
   assign ln.id_en           = (state_r == ST_SEND_ID);
   assign ln.id_val          = DEVICE_ID;
   assign busy_flag          = busy_r;
   assign write_unlock_latch = latch_r;
   assign quad_command_mode  = quad_r;
   assign sleep_mode         = sleep_r;
   assign clear_start        = start_r;
   assign clear_kind         = kind_r;
   assign clear_base         = base_r;

   // =========================================================================
   // assertions
   a_unlock_needed: assert property ( // [RULE5]
      @(posedge clk) disable iff (!resetn)
      $rose(busy_r) |-> $past(latch_r) && start_r)
      else $error("erase began without the unlock latch");

   a_latch_cleared: assert property ( // [RULE10]
      @(posedge clk) disable iff (!resetn)
      $rose(busy_r) |-> !latch_r ##1 busy_r)
      else $error("unlock latch still set in erase cycle");

   a_sector_start: assert property ( // [RULE1]
      @(posedge clk) disable iff (!resetn)
      ln.sel_rise && listen && state_r == ST_TAKE_ADDR &&
      cmd_r == CMD_SMALL_CLEAR && exact_addr && latch_r &&
      !fes_protected(prot_r, addr_r)
      |=> busy_r && kind_r == CLR_SMALL && base_r[11:0] == 12'h000)
      else $error("sector erase not started on exact release");

   a_exact_release: assert property ( // [RULE6]
      @(posedge clk) disable iff (!resetn)
      ln.sel_rise && !busy_r && addr_cmd && !exact_addr |=> !busy_r)
      else $error("address erase ran on a wrong release point");

   a_full_guarded: assert property ( // [RULE12]
      @(posedge clk) disable iff (!resetn)
      ln.sel_rise && !busy_r && full_cmd && prot_r != 4'h0 |=> !busy_r)
      else $error("whole erase ran with protection set");

   a_sleep_entry: assert property ( // [RULE13]
      @(posedge clk) disable iff (!resetn)
      pwr_r == PW_SLEEP && $past(pwr_r) != PW_SLEEP
      |-> $past(pwr_r) == PW_ENTER && $past(pwr_cnt_r) == 32'h0)
      else $error("sleep entered without the entry delay");

   a_sleep_ignore: assert property ( // [RULE14]
      @(posedge clk) disable iff (!resetn)
      pwr_r == PW_SLEEP && ln.byte_vld && state_r == ST_WAIT_CMD &&
      ln.byte_val != CMD_WAKE_ID
      |=> state_r == ST_DROP && $stable(latch_r) && $stable(quad_r))
      else $error("command taken while asleep");

   a_busy_awake: assert property ( // [RULE15]
      @(posedge clk) disable iff (!resetn)
      busy_r |-> pwr_r == PW_AWAKE)
      else $error("sleep state reached during an erase cycle");

   a_busy_no_decode: assert property ( // [RULE20]
      @(posedge clk) disable iff (!resetn)
      busy_r && ln.byte_vld && state_r == ST_WAIT_CMD |=> state_r == ST_DROP)
      else $error("command decoded during an erase cycle");

   a_wake_finish: assert property ( // [RULE17]
      @(posedge clk) disable iff (!resetn)
      pwr_r == PW_WAKE && pwr_cnt_r == 32'h0 |=> pwr_r == PW_AWAKE)
      else $error("wake delay did not end in standby");

endmodule : fes_top

// *** tb/fes_host.sv ***
// host side link driver for the erase and sleep block
`timescale 1ns/1ps
module fes_host (
   output logic        sclk,
   output logic        select_n,
   output logic [3:0]  dq,
   input  wire logic   so,
   output logic [47:0] rx
);
   initial begin
      sclk = 1'b0;
      select_n = 1'b1;
      dq = 4'h0;
      rx = 48'h0;
   end
   // gap first, then n bits msb first; link clock idles low
   task automatic frame(input logic [47:0] d, input int n);
      #300;
      select_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         sclk = 1'b0;
         dq[0] = d[47-i];
         #40;
         sclk = 1'b1;
         #40;
         rx = {rx[46:0], so};
      end
      sclk = 1'b0;
      #40;
      select_n = 1'b1;
      dq = ~dq;
   endtask : frame
   // n nibbles, high nibble first, on all four lines for quad mode
   task automatic qframe(input logic [47:0] d, input int n);
      #300;
      select_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         sclk = 1'b0;
         dq = d[47-4*i -: 4];
         #40;
         sclk = 1'b1;
         #40;
      end
      sclk = 1'b0;
      #40;
      select_n = 1'b1;
      dq = ~dq;
   endtask : qframe
endmodule : fes_host

// *** tb/testbench.sv ***
// self-checking bench for the erase and sleep control block
`timescale 1ns/1ps
module testbench;
   import fes_pkg::*;
   localparam int unsigned CYC = 300;
   localparam int unsigned DLY = 20;
   localparam logic [7:0]  ID  = 8'h5a; // arbitrary value
   typedef struct packed {
      logic [7:0] c; logic [23:0] a; logic [3:0] p;
      logic r; logic [1:0] k; logic [23:0] b;
   } fes_row_t;
   fes_row_t rows [7] = '{
      {8'hc7, 24'h0, 4'h1, 1'b0, 2'h3, 24'h0},
      {8'hd8, 24'h3f1234, 4'h1, 1'b0, 2'h2, 24'h0},
      {8'h52, 24'h12abcd, 4'h0, 1'b1, 2'h1, 24'h128000},
      {8'hd8, 24'h12abcd, 4'h0, 1'b1, 2'h2, 24'h120000},
      {8'hc7, 24'h0, 4'h0, 1'b1, 2'h3, 24'h0},
      {8'h60, 24'h0, 4'h0, 1'b1, 2'h3, 24'h0},
      {8'h20, 24'h123456, 4'h1, 1'b1, 2'h0, 24'h123000}};
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [3:0]  prot = 4'h0;
   logic        sclk, select_n, so, so_oe, busy, latch, quad, sleep, start;
   logic [3:0]  dq;
   logic [1:0]  kind;
   logic [23:0] base;
   logic [47:0] rx;
   logic        hit;
   logic        oe_seen = 1'b0;
   int          err_total = 0;
   int          check_count = 0;
   int          cycles = 0;
   fes_host u (.sclk(sclk), .select_n(select_n), .dq(dq), .so(so), .rx(rx));
   fes_top #(.SMALL_CYC(CYC), .HALF_CYC(CYC), .BLOCK_CYC(CYC),
      .FULL_CYC(CYC), .SLEEP_CYC(DLY), .WAKE_CYC_P(DLY),
      .WAKE_ID_CYC_P(DLY), .DEVICE_ID(ID)) uut (
      .clk(clk), .resetn(resetn), .sclk(sclk), .select_n(select_n),
      .dq_in(dq), .protect_bits(prot), .serial_out(so),
      .serial_out_oe(so_oe), .busy_flag(busy), .write_unlock_latch(latch),
      .quad_command_mode(quad), .sleep_mode(sleep), .clear_start(start),
      .clear_kind(kind), .clear_base(base));
   always #5 clk = ~clk;
   always @(posedge clk)
      if (so_oe === 1'b1) oe_seen <= 1'b1;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         final_report;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_start;
      hit = 1'b0;
      repeat (60) begin
         @(posedge clk);
         #1;
         if (start === 1'b1) hit = 1'b1;
      end
   endtask : wait_start
   task automatic final_report;
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   initial begin
      repeat (8) @(posedge clk);
      #1 resetn = 1'b1;
      chk({busy, latch, quad, sleep, start}, 0);
      foreach (rows[i]) begin
         @(posedge clk);
         #1 prot = rows[i].p;
         u.frame({CMD_WRITE_UNLK, 40'h0}, 8);
         chk(latch, 1);
         u.frame({rows[i].c, rows[i].a, 16'h0}, rows[i].k == 2'h3 ? 8 : 32);
         wait_start;
         chk(hit, rows[i].r);
         if (rows[i].r) begin
            chk({kind, base}, {rows[i].k, rows[i].b});
            chk({busy, latch}, 2'b10);
            repeat (CYC - 80) @(posedge clk);
            chk(busy, 1);
            repeat (40) @(posedge clk);
            chk(busy, 0);
         end else
            chk(latch, 1);
         $display("row %0d done", i);
      end
      #1 prot = 4'h0;
      u.frame({CMD_SMALL_CLEAR, 40'h0}, 32);
      wait_start;
      chk(hit, 0);
      u.frame({CMD_WRITE_UNLK, 40'h0}, 8);
      u.frame({CMD_SMALL_CLEAR, 40'h0}, 31);
      wait_start;
      chk(hit, 0);
      u.frame({CMD_FULL_A, 40'h0}, 9);
      wait_start;
      chk(hit, 0);
      u.frame({CMD_SLEEP_ENTRY, 40'h0}, 9);
      wait_start;
      chk({hit, sleep}, 0);
      $display("release point tests done");
      u.frame({CMD_SLEEP_ENTRY, 40'h0}, 8);
      repeat (10) @(posedge clk);
      #1 chk(sleep, 0);
      repeat (DLY) @(posedge clk);
      #1 chk(sleep, 1);
      u.frame({CMD_FULL_A, 40'h0}, 8);
      wait_start;
      chk({hit, sleep}, 2'b01);
      u.frame({CMD_WAKE_ID, 40'h0}, 8);
      repeat (DLY + 10) @(posedge clk);
      #1 chk(sleep, 0);
      $display("sleep tests done");
      u.frame({CMD_FULL_B, 40'h0}, 8);
      wait_start;
      u.frame({CMD_SLEEP_ENTRY, 40'h0}, 8);
      repeat (DLY + 10) @(posedge clk);
      #1 chk({hit, busy, sleep}, 3'b110);
      repeat (CYC) @(posedge clk);
      #1 chk(oe_seen, 0);
      u.frame({CMD_WAKE_ID, 40'h0}, 48);
      chk(rx[15:0], {ID, ID});
      chk(oe_seen, 1);
      $display("id test done");
      u.frame({CMD_QUAD_ENTER, 40'h0}, 8);
      chk(quad, 1);
      u.qframe({CMD_WRITE_UNLK, 40'h0}, 2);
      chk(latch, 1);
      u.qframe({CMD_BLOCK_CLEAR, 24'h3a5678, 16'h0}, 8);
      wait_start;
      chk(hit, 1);
      chk({kind, base}, {2'h2, 24'h3a0000});
      $display("quad test done");
      final_report;
   end
endmodule : testbench
